// ==== bench/capture_trigger_control_bench.sv ====
module capture_trigger_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ctc_pkg::*;
  localparam int LEN = 16; // short record keeps the run brief
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic ext_trig = 1'b0;
  logic run = 1'b0;
  logic cap_ready = 1'b1;
  ctc_cfg_type cfg = '0;
  ctc_events_type ev = '0;
  // design outputs
  logic samp_valid, samp_ready, samp_level, cap_valid;
  logic [SAMPLE_W-1:0] samp_data;
  ctc_word_type cap_word;
  logic armed_q, triggered_q, done_q, sqw_fast_q;
  logic [CNT_W-1:0] trig_pos_q, wr_cnt_q, sqw_edges_q, sqw_first_q;
  logic [CNT_W-1:0] sqw_last_q;
  logic [CS_FRAME_W-1:0] cs_frame_q;
  logic [CS_BYTE_W-1:0] cs_byte_q;
  // scoreboard
  int mismatches = 0;
  int checks = 0;
  int nwords = 0;
  int ntrig = 0;
  int trig_idx = 0;
  logic [SAMPLE_W-1:0] d0, prev, trig_data;
  logic want_em; // expected edge marker of a word

  always #12.5 clock = ~clock;

  ctc_far_model far (.clock(clock), .reset_n(reset_n), .run(run),
    .samp_valid(samp_valid), .samp_ready(samp_ready),
    .samp_data(samp_data), .samp_level(samp_level));

  ctc_trigger #(.CAP_LEN(LEN)) dut (.clock(clock), .reset_n(reset_n),
    .clock_en(1'b1), .start(start), .cfg(cfg), .ev(ev),
    .ext_trig(ext_trig), .samp_valid(samp_valid), .samp_ready(samp_ready),
    .samp_data(samp_data), .samp_level(samp_level), .cap_valid(cap_valid),
    .cap_ready(cap_ready), .cap_word(cap_word), .armed_q(armed_q),
    .triggered_q(triggered_q), .done_q(done_q), .trig_pos_q(trig_pos_q),
    .wr_cnt_q(wr_cnt_q), .sqw_edges_q(sqw_edges_q),
    .sqw_first_q(sqw_first_q), .sqw_last_q(sqw_last_q),
    .sqw_fast_q(sqw_fast_q), .cs_frame_q(cs_frame_q),
    .cs_byte_q(cs_byte_q));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic close_out;
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // buffer side: sampled mid-cycle, the word is taken at the next edge
  always @(negedge clock) begin
    if (cap_valid && cap_ready) begin
      if (nwords == 0) d0 = cap_word.data;
      else check(cap_word.data, {prev + 8'h01});
      // level toggles every sample, so each word is an edge
      want_em = cfg.sqw_mode & (cap_word.data[0] ~^ cfg.sqw_rising);
      check(cap_word.edge_mark, want_em);
      prev = cap_word.data;
      if (cap_word.trig) begin
        ntrig++;
        trig_idx = nwords;
        trig_data = cap_word.data;
      end
      nwords++;
    end
  end

  // 0 triggered, 1 done, 2 word waiting
  function automatic logic pick(input int w);
    return (w == 0) ? triggered_q : (w == 1) ? done_q : cap_valid;
  endfunction : pick

  // bounded wait; running out ends the run
  task automatic wait_lvl(input int w, input logic lvl, input int limit);
    for (int i = 0; i < limit; i++) begin
      @(posedge clock);
      #1;
      if (pick(w) === lvl) return;
    end
    mismatches++;
    close_out;
  endtask : wait_lvl

  task automatic arm(input ctc_cfg_type c);
    @(posedge clock);
    cfg <= c;
    start <= 1'b1;
    nwords = 0;
    ntrig = 0;
    @(posedge clock);
    start <= 1'b0;
  endtask : arm

  task automatic pulse(input ctc_events_type e);
    @(posedge clock);
    ev <= e;
    @(posedge clock);
    ev <= '0;
  endtask : pulse

  // finish a capture and let the buffer drain
  task automatic finish_cap;
    wait_lvl(1, 1'b1, 4 * LEN);
    wait_lvl(2, 1'b0, 8);
  endtask : finish_cap

  function automatic ctc_events_type evmap(input logic [SRC_W-1:0] s);
    ctc_events_type e;
    e = '0;
    case (s)
      SRC_RX_A: e.rx_pre_a = 1'b1;
      SRC_TX_A: e.tx_pre_a = 1'b1;
      SRC_RX_B: e.rx_pre_b = 1'b1;
      SRC_TX_B: e.tx_pre_b = 1'b1;
      SRC_RX_ERR: e.rx_err = 4'hf;
      SRC_RX_BLK: e.rx_block = 1'b1;
      SRC_JIT: e.jit_zero = 1'b1;
      SRC_CM: e.cm_zero = 1'b1;
      SRC_NOISE: e.noise_rep = 1'b1;
      SRC_DGEN: e.dgen_zero = 1'b1;
      SRC_TX_BLK: e.tx_block = 1'b1;
      SRC_SYNC_A: e.sync_pre_a = 1'b1;
      SRC_SYNC_B: e.sync_pre_b = 1'b1;
      SRC_SYNC_ERR: e.sync_err = 4'hf;
      SRC_SYNC_BLK: e.sync_block = 1'b1;
      SRC_REF_A: e.ref_pre_a = 1'b1;
      SRC_REF_B: e.ref_pre_b = 1'b1;
      default: e = '0;
    endcase
    e.jit_gen_on = (s == SRC_JIT);
    return e;
  endfunction : evmap

  // every event source but the external pin and input crossing: the next source's event first (jitter: its own, generator off), then its own
  task automatic src_table;
    ctc_cfg_type c;
    ctc_events_type w;
    for (int i = 0; i < SRC_COUNT; i++) begin
      c = '0;
      c.src = i[SRC_W-1:0];
      c.err_mask = 4'hf;
      if (c.src != SRC_EXT && c.src != SRC_IN_ZX) begin
        w = evmap(c.src + 5'h01);
        if (c.src == SRC_JIT) w = '0; // generator off
        if (c.src == SRC_JIT) w.jit_zero = 1'b1;
        arm(c);
        pulse(w);
        repeat (2) @(posedge clock);
        #1;
        check(triggered_q, 1'b0);
        check(armed_q, 1'b1);
        pulse(evmap(c.src));
        wait_lvl(0, 1'b1, 4);
        pulse(evmap(c.src));
        finish_cap;
        check(ntrig, 1);
        check(trig_idx, 0);
        check(wr_cnt_q, LEN);
      end
    end
  endtask : src_table

  // external pin, both slopes, buffer stalled until it refuses
  task automatic ext_post;
    ctc_cfg_type c;
    for (int sl = 0; sl < 2; sl++) begin
      c = '0;
      c.src = SRC_EXT;
      c.slope_pos = sl[0];
      @(posedge clock);
      ext_trig <= ~sl[0];
      arm(c);
      @(posedge clock);
      cap_ready <= 1'b0;
      ext_trig <= sl[0];
      wait_lvl(0, 1'b1, 4);
      repeat (4) @(posedge clock);
      #1;
      check(samp_ready, 1'b0);
      @(posedge clock);
      ext_trig <= ~sl[0];
      @(posedge clock);
      ext_trig <= sl[0];
      cap_ready <= 1'b1;
      finish_cap;
      check(ntrig, 1);
      check(nwords, LEN);
      check(trig_pos_q, 0);
    end
  endtask : ext_post

  // pre-trigger on a coding error: marked word is the last one
  task automatic pre_err;
    ctc_cfg_type c;
    ctc_events_type e;
    c = '0;
    c.src = SRC_RX_ERR;
    c.pre_mode = 1'b1;
    c.err_mask = 4'h2;
    e = '0;
    e.rx_err = 4'h2;
    arm(c);
    repeat (3) @(posedge clock);
    pulse(e);
    finish_cap;
    check(ntrig, 1);
    check(trig_idx, nwords - 1);
    check(trig_pos_q, trig_idx);
    check(wr_cnt_q, nwords);
  endtask : pre_err

  // each error type alone, masked then enabled, on both inputs
  task automatic err_masks;
    ctc_cfg_type c;
    ctc_events_type e;
    for (int j = 0; j < 2 * ERR_TYPES; j++) begin
      c = '0;
      c.src = j[0] ? SRC_SYNC_ERR : SRC_RX_ERR;
      c.err_mask = ~(4'h1 << (j / 2));
      e = '0;
      e.rx_err = 4'h1 << (j / 2);
      e.sync_err = e.rx_err;
      arm(c);
      pulse(e);
      repeat (2) @(posedge clock);
      #1;
      check(triggered_q, 1'b0);
      c.err_mask = 4'h1 << (j / 2);
      e = '0;
      if (j[0]) e.rx_err = c.err_mask;
      else e.sync_err = c.err_mask;
      arm(c);
      pulse(e);
      repeat (2) @(posedge clock);
      #1;
      check(triggered_q, 1'b0);
      if (j[0]) e.sync_err = c.err_mask;
      else e.rx_err = c.err_mask;
      pulse(e);
      wait_lvl(0, 1'b1, 4);
      check(triggered_q, 1'b1);
      finish_cap;
    end
  endtask : err_masks

  // square-wave mode: preamble choices free-run, edge polarity kept
  task automatic sqw_run;
    ctc_cfg_type c;
    for (int s = 0; s < 4; s++) begin
      c = '0;
      c.src = s[SRC_W-1:0];
      c.sqw_mode = 1'b1;
      c.sqw_rising = s[0];
      arm(c);
      wait_lvl(0, 1'b1, 3);
      finish_cap;
      check(sqw_fast_q, 1'b1);
      check({d0[0] ^ ~sqw_first_q[0]}, s[0]);
      check({d0[0] ^ ~sqw_last_q[0]}, s[0]);
      check(sqw_edges_q, LEN / 2);
    end
  endtask : sqw_run

  // input crossing on each slope: marked sample has the new level
  task automatic zero_cross;
    ctc_cfg_type c;
    for (int sl = 0; sl < 2; sl++) begin
      c = '0;
      c.src = SRC_IN_ZX;
      c.slope_pos = sl[0];
      arm(c);
      wait_lvl(0, 1'b1, 4);
      finish_cap;
      check(trig_data[0], sl[0]);
    end
  endtask : zero_cross

  // status frame count wraps after 192 frames, 24 bytes
  task automatic status_frames;
    ctc_events_type e;
    e = '0;
    e.rx_block = 1'b1;
    pulse(e);
    e = '0;
    e.rx_pre_a = 1'b1;
    repeat (191) pulse(e);
    #1;
    check(cs_frame_q, 191);
    check(cs_byte_q, 23);
    repeat (9) pulse(e);
    #1;
    check(cs_frame_q, 8);
    check(cs_byte_q, 1);
  endtask : status_frames

  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    run <= 1'b1;
    @(posedge clock);
    #1;
    check(armed_q, 1'b0);
    check(cap_valid, 1'b0);
    check(samp_ready, 1'b1);
    src_table;
    ext_post;
    pre_err;
    err_masks;
    sqw_run;
    zero_cross;
    status_frames;
    close_out;
  end
endmodule : capture_trigger_control_bench

// ==== bench/ctc_far_model.sv ====
// far side of the sampled interface: a stream of slicer samples
module ctc_far_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // stream control
  input wire logic run,
  // sample stream
  output logic samp_valid,
  input wire logic samp_ready,
  output logic [ctc_pkg::SAMPLE_W-1:0] samp_data,
  output logic samp_level
);
  timeunit 1ns;
  timeprecision 100ps;
  import ctc_pkg::*;
  logic [SAMPLE_W-1:0] count_q; // next sample value

  // advance only on a taken beat, so a stall never drops a sample
  always @(posedge clock) begin
    if (!reset_n) begin
      count_q <= 8'h00;
    end else if (samp_valid && samp_ready) begin
      count_q <= count_q + 8'h01;
    end
  end
  assign samp_valid = run;
  // idle stream shows inverted data, not a stale word
  assign samp_data = run ? count_q : ~count_q;
  // level follows bit zero: a crossing on every sample
  assign samp_level = samp_data[0];
endmodule : ctc_far_model

// ==== shared/ctc_pkg.sv ====
package ctc_pkg;

  // sampling of the interface signal
  localparam int SAMPLE_RATE_HZ = 80_000_000;
  localparam int RECORD_SAMPLES = 1_500_000; // about 19 ms at the sample rate
  localparam int CNT_W = 21;
  localparam int SAMPLE_W = 8;

  // square-wave jitter input limit, and the least edge spacing it implies
  localparam int SQW_MAX_HZ = 13_000_000;
  localparam int SQW_MIN_GAP = SAMPLE_RATE_HZ / SQW_MAX_HZ;
  localparam int GAP_W = 4;

  // channel status block layout
  localparam int CS_FRAMES = 192;
  localparam int CS_BYTE_SHIFT = 3; // eight frames make one status byte
  localparam int CS_FRAME_W = 8;
  localparam int CS_BYTE_W = 5;

  // error flag positions
  localparam int ERR_TYPES = 4;
  localparam int ERR_PARITY = 0;
  localparam int ERR_CODING = 1;
  localparam int ERR_LOCK = 2;
  localparam int ERR_CONFIDENCE = 3;

  // trigger source codes
  localparam int SRC_W = 5;
  localparam int SRC_COUNT = 19;
  localparam logic [SRC_W-1:0] SRC_RX_A = 5'h00;
  localparam logic [SRC_W-1:0] SRC_TX_A = 5'h01;
  localparam logic [SRC_W-1:0] SRC_RX_B = 5'h02;
  localparam logic [SRC_W-1:0] SRC_TX_B = 5'h03;
  localparam logic [SRC_W-1:0] SRC_RX_ERR = 5'h04;
  localparam logic [SRC_W-1:0] SRC_RX_BLK = 5'h05;
  localparam logic [SRC_W-1:0] SRC_JIT = 5'h06;
  localparam logic [SRC_W-1:0] SRC_EXT = 5'h07;
  localparam logic [SRC_W-1:0] SRC_CM = 5'h08;
  localparam logic [SRC_W-1:0] SRC_NOISE = 5'h09;
  localparam logic [SRC_W-1:0] SRC_DGEN = 5'h0a;
  localparam logic [SRC_W-1:0] SRC_TX_BLK = 5'h0b;
  localparam logic [SRC_W-1:0] SRC_SYNC_A = 5'h0c;
  localparam logic [SRC_W-1:0] SRC_SYNC_B = 5'h0d;
  localparam logic [SRC_W-1:0] SRC_SYNC_ERR = 5'h0e;
  localparam logic [SRC_W-1:0] SRC_SYNC_BLK = 5'h0f;
  localparam logic [SRC_W-1:0] SRC_IN_ZX = 5'h10;
  localparam logic [SRC_W-1:0] SRC_REF_A = 5'h11;
  localparam logic [SRC_W-1:0] SRC_REF_B = 5'h12;

  // capture state, one-hot
  typedef enum logic [3:0] {
    CTC_IDLE = 4'h1,
    CTC_ARMED = 4'h2,
    CTC_POST = 4'h4,
    CTC_DONE = 4'h8
  } ctc_state_type;

  // configuration bits
  typedef struct packed {
    logic [SRC_W-1:0] src;
    logic slope_pos;
    logic pre_mode;
    logic sqw_mode;
    logic sqw_rising;
    logic [ERR_TYPES-1:0] err_mask;
  } ctc_cfg_type;

  // event pulses from the interface, generators and reference
  typedef struct packed {
    logic rx_pre_a;
    logic rx_pre_b;
    logic tx_pre_a;
    logic tx_pre_b;
    logic sync_pre_a;
    logic sync_pre_b;
    logic ref_pre_a;
    logic ref_pre_b;
    logic rx_block;
    logic tx_block;
    logic sync_block;
    logic [ERR_TYPES-1:0] rx_err;
    logic [ERR_TYPES-1:0] sync_err;
    logic jit_gen_on;
    logic jit_zero;
    logic cm_zero;
    logic noise_rep;
    logic dgen_zero;
  } ctc_events_type;

  // one word toward the capture buffer
  typedef struct packed {
    logic [SAMPLE_W-1:0] data;
    logic trig;
    logic edge_mark;
  } ctc_word_type;

  localparam int WORD_W = $bits(ctc_word_type);

endpackage : ctc_pkg

// ==== src/ctc_skid.sv ====
// two-entry buffer; head register drives the output directly
module ctc_skid #(
  parameter int W = 8
) (
  // clock and control
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] head_q; // oldest word
  logic [W-1:0] tail_q; // second word
  logic hv_q; // head holds a word
  logic tv_q; // tail holds a word
  logic rdy_q; // registered copy of tail empty, so ready leaves a flop

  wire push = in_valid & ~tv_q;
  wire pop = hv_q & out_ready;

  assign in_ready = rdy_q;
  assign out_valid = hv_q;
  assign out_data = head_q;

  // tail only fills while the head is stalled, so order is kept
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hv_q <= 1'b0;
      tv_q <= 1'b0;
      rdy_q <= 1'b1;
      head_q <= '0;
      tail_q <= '0;
    end else if (clock_en) begin
      if (pop) begin
        if (tv_q) begin
          head_q <= tail_q;
          tv_q <= push;
          rdy_q <= ~push;
          if (push) begin
            tail_q <= in_data;
          end
        end else begin
          hv_q <= push;
          if (push) begin
            head_q <= in_data;
          end
        end
      end else if (push) begin
        if (!hv_q) begin
          head_q <= in_data;
          hv_q <= 1'b1;
        end else begin
          tail_q <= in_data;
          tv_q <= 1'b1;
          rdy_q <= 1'b0;
        end
      end
    end
  end

endmodule : ctc_skid

// ==== src/ctc_trigger.sv ====
// Function
// RL1: square-wave clocks up to 13 MHz are captured
// RL2: edge polarity picks rising or falling edges
// RL3: channel preamble choices free-run in square-wave mode
// RL4: pre keeps record before, post after trigger
// RL5: jitter generator trigger only while generator on
// RL6: square-wave frequency estimated from the record
// RL7: jitter referenced to average-frequency ideal clock
// RL8: preamble triggers align first wide pulse end
// RL9: receive preamble trigger on first selected preamble
// RL10: record continues with rest of preamble
// RL11: transmit preamble trigger at own preamble start
// RL12: receive error trigger, four masked error types
// RL13: error capture precedes or follows first error
// RL14: validity flag never counts as an error
// RL15: sync error trigger mirrors receive error trigger
// RL16: block triggers on first block preamble
// RL17: status block is 192 frames, 24 bytes
// RL18: impairment generators trigger at crossings, repeats
// RL19: digital generator trigger at waveform zero crossings
// RL20: input crossing trigger on selected slope
// RL21: external trigger on sample after selected edge
// RL22: capture holds 1.5 million samples at 80 MHz
// RL23: one trigger per arming, later events ignored
module ctc_trigger
  import ctc_pkg::*;
#(
  parameter int CAP_LEN = ctc_pkg::RECORD_SAMPLES,
  parameter int CNT_BITS = ctc_pkg::CNT_W,
  parameter int DATA_W = ctc_pkg::SAMPLE_W
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // control and configuration
  input wire logic start,
  input wire ctc_pkg::ctc_cfg_type cfg,
  // events and pins
  input wire ctc_pkg::ctc_events_type ev,
  input wire logic ext_trig,
  // sampled interface signal
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic [DATA_W-1:0] samp_data,
  input wire logic samp_level,
  // words toward the capture buffer
  output logic cap_valid,
  input wire logic cap_ready,
  output ctc_pkg::ctc_word_type cap_word,
  // status
  output logic armed_q,
  output logic triggered_q,
  output logic done_q,
  output logic [CNT_BITS-1:0] trig_pos_q,
  output logic [CNT_BITS-1:0] wr_cnt_q,
  output logic [CNT_BITS-1:0] sqw_edges_q,
  output logic [CNT_BITS-1:0] sqw_first_q,
  output logic [CNT_BITS-1:0] sqw_last_q,
  output logic sqw_fast_q,
  output logic [CS_FRAME_W-1:0] cs_frame_q,
  output logic [CS_BYTE_W-1:0] cs_byte_q
);
  import ctc_pkg::*;

  // elaboration checks
  if (CAP_LEN < 2 || CAP_LEN >= (2 ** CNT_BITS)) begin : g_bad_len
    $error("capture length does not fit the counter");
  end
  if (DATA_W != SAMPLE_W) begin : g_bad_w
    $error("sample width must match the word layout");
  end

  localparam logic [CNT_BITS-1:0] LEN_LAST = CNT_BITS'(CAP_LEN - 1);
  localparam logic [CNT_BITS-1:0] LEN_FULL = CNT_BITS'(CAP_LEN);
  localparam logic [CNT_BITS-1:0] CNT_MAX = '1;
  localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(SQW_MIN_GAP);
  localparam logic [GAP_W-1:0] GAP_MAX = '1;
  localparam logic [CS_FRAME_W-1:0] CS_LAST = CS_FRAME_W'(CS_FRAMES - 1);

  ctc_state_type state_q; // capture state
  ctc_state_type state_d;
  logic lvl_prev_q; // previous interface level, per sample
  logic ext_prev_q; // previous external pin level, per clock
  logic ext_hit_q; // external edge seen, waits for next sample
  logic [GAP_W-1:0] gap_q; // samples since last timed edge
  logic [CNT_BITS-1:0] wr_cnt_d;
  logic [CS_FRAME_W-1:0] cs_frame_d;
  logic [SRC_COUNT-1:0] ev_vec; // one line per trigger source
  logic [ERR_TYPES-1:0] rx_err_hit;
  logic [ERR_TYPES-1:0] sync_err_hit;
  logic fifo_ready;
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_in;
  logic [WORD_W-1:0] fifo_out;

  // sample handshake and edge decode
  wire beat = clock_en & samp_valid & fifo_ready;
  wire lvl_rise = samp_level & ~lvl_prev_q;
  wire lvl_fall = ~samp_level & lvl_prev_q;
  wire zx_hit = cfg.slope_pos ? lvl_rise : lvl_fall; // RL20
  wire sqw_edge = cfg.sqw_mode & (cfg.sqw_rising ? lvl_rise : lvl_fall); // RL2
  wire ext_edge = cfg.slope_pos ? (ext_trig & ~ext_prev_q)
                                : (~ext_trig & ext_prev_q);

  // the error mask is shared by receive and sync errors
  for (genvar g = 0; g < ERR_TYPES; g++) begin : g_err
    assign rx_err_hit[g] = ev.rx_err[g] & cfg.err_mask[g]; // RL12
    assign sync_err_hit[g] = ev.sync_err[g] & cfg.err_mask[g]; // RL15
  end

  // validity is not an input here at all, so it can never trigger
  wire rx_err_any = |rx_err_hit; // RL14
  wire sync_err_any = |sync_err_hit; // RL15

  // channel preamble choices ignore their pulses in square-wave mode
  wire free_run = cfg.sqw_mode; // RL3

  // source table; preamble markers arrive at the end of the first
  // wide pulse (receive side) or at preamble start (transmit side)
  assign ev_vec[SRC_RX_A] = free_run | ev.rx_pre_a; // RL8 RL9 RL10
  assign ev_vec[SRC_TX_A] = free_run | ev.tx_pre_a; // RL11
  assign ev_vec[SRC_RX_B] = free_run | ev.rx_pre_b; // RL9
  assign ev_vec[SRC_TX_B] = free_run | ev.tx_pre_b; // RL11
  assign ev_vec[SRC_RX_ERR] = rx_err_any; // RL12 RL13
  assign ev_vec[SRC_RX_BLK] = ev.rx_block; // RL16
  assign ev_vec[SRC_JIT] = ev.jit_gen_on & ev.jit_zero; // RL5 RL18
  assign ev_vec[SRC_EXT] = ext_hit_q; // RL21
  assign ev_vec[SRC_CM] = ev.cm_zero; // RL18
  assign ev_vec[SRC_NOISE] = ev.noise_rep; // RL18
  assign ev_vec[SRC_DGEN] = ev.dgen_zero; // RL19
  assign ev_vec[SRC_TX_BLK] = ev.tx_block; // RL16
  assign ev_vec[SRC_SYNC_A] = ev.sync_pre_a; // RL8
  assign ev_vec[SRC_SYNC_B] = ev.sync_pre_b; // RL8
  assign ev_vec[SRC_SYNC_ERR] = sync_err_any; // RL15
  assign ev_vec[SRC_SYNC_BLK] = ev.sync_block; // RL16
  assign ev_vec[SRC_IN_ZX] = zx_hit; // RL20
  assign ev_vec[SRC_REF_A] = ev.ref_pre_a; // RL8
  assign ev_vec[SRC_REF_B] = ev.ref_pre_b; // RL8

  // unknown source codes never fire
  wire src_ok = cfg.src < SRC_W'(SRC_COUNT);
  wire ev_sel = src_ok & ev_vec[cfg.src];

  // only an armed block can fire, and only on a sample
  wire fire = (state_q == CTC_ARMED) & beat & ev_sel & ~start; // RL23

  // pre mode writes from arming to trigger, post from trigger on
  wire wr_pre = (state_q == CTC_ARMED) & cfg.pre_mode; // RL4 RL13
  wire wr_post = (state_q == CTC_POST) | (fire & ~cfg.pre_mode); // RL4
  wire wr_now = beat & ~start & (wr_pre | wr_post);
  wire post_end = (state_q == CTC_POST) & wr_now & (wr_cnt_q == LEN_LAST);

  // word to the buffer: sample plus markers
  assign fifo_in = {samp_data, fire, sqw_edge}; // RL1

  // two-entry buffer; a stalled buffer holds the source off
  ctc_skid #(
    .W(WORD_W)
  ) u_skid (
    .clock(clock),
    .reset_n(reset_n),
    .clock_en(clock_en),
    .in_valid(wr_now),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(cap_ready),
    .out_data(fifo_out)
  );

  assign samp_ready = fifo_ready;
  assign cap_valid = fifo_valid;
  assign cap_word = ctc_word_type'(fifo_out);

  // next state; a start command always re-arms
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CTC_IDLE: begin
        if (start) state_d = CTC_ARMED;
      end
      CTC_ARMED: begin
        if (start) state_d = CTC_ARMED;
        else if (fire && cfg.pre_mode) state_d = CTC_DONE; // RL4
        else if (fire) state_d = CTC_POST;
      end
      CTC_POST: begin
        if (start) state_d = CTC_ARMED;
        else if (post_end) state_d = CTC_DONE; // RL22
      end
      CTC_DONE: begin
        if (start) state_d = CTC_ARMED;
      end
      default: state_d = CTC_IDLE;
    endcase
  end

  // written-sample count; post mode restarts it at the trigger word
  always_comb begin
    wr_cnt_d = wr_cnt_q;
    if (start) begin
      wr_cnt_d = '0;
    end else if (fire && !cfg.pre_mode) begin
      wr_cnt_d = CNT_BITS'(1);
    end else if (wr_now && wr_cnt_q != LEN_FULL) begin
      wr_cnt_d = wr_cnt_q + CNT_BITS'(1); // RL22
    end
  end

  // status block frame index, restarted by each receive block preamble
  always_comb begin
    cs_frame_d = cs_frame_q;
    if (ev.rx_block) begin
      cs_frame_d = '0; // RL17
    end else if (ev.rx_pre_a) begin
      cs_frame_d = (cs_frame_q == CS_LAST) ? '0
                 : cs_frame_q + CS_FRAME_W'(1); // RL17
    end
  end

  // capture state and its status flags
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q <= CTC_IDLE;
      armed_q <= 1'b0;
      triggered_q <= 1'b0;
      done_q <= 1'b0;
      wr_cnt_q <= '0;
      trig_pos_q <= '0;
    end else if (clock_en) begin
      state_q <= state_d;
      armed_q <= (state_d == CTC_ARMED);
      triggered_q <= start ? 1'b0 : (triggered_q | fire); // RL23
      done_q <= (state_d == CTC_DONE);
      wr_cnt_q <= wr_cnt_d;
      if (fire) begin
        trig_pos_q <= wr_cnt_q; // RL13
      end
    end
  end

  // pin history; an external edge waits for the next sample
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ext_prev_q <= 1'b0;
      ext_hit_q <= 1'b0;
      lvl_prev_q <= 1'b0;
    end else if (clock_en) begin
      ext_prev_q <= ext_trig;
      // a new edge wins over the consuming sample
      if (ext_edge) ext_hit_q <= 1'b1; // RL21
      else if (beat || start) ext_hit_q <= 1'b0;
      if (beat) lvl_prev_q <= samp_level;
    end
  end

  // square-wave edge statistics: the first and last timed edge and
  // their count give the average period for the ideal reference
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sqw_edges_q <= '0;
      sqw_first_q <= '0;
      sqw_last_q <= '0;
      sqw_fast_q <= 1'b0;
      gap_q <= '0;
    end else if (clock_en) begin
      if (start) begin
        sqw_edges_q <= '0;
        sqw_fast_q <= 1'b0;
        gap_q <= '0;
      end else if (wr_now && sqw_edge) begin
        if (sqw_edges_q == '0) sqw_first_q <= wr_cnt_d; // RL6
        sqw_last_q <= wr_cnt_d; // RL7
        if (sqw_edges_q != CNT_MAX) sqw_edges_q <= sqw_edges_q + CNT_BITS'(1);
        // edges closer than the 13 MHz limit mark an unusable record
        if (sqw_edges_q != '0 && gap_q < GAP_MIN) sqw_fast_q <= 1'b1; // RL1
        gap_q <= GAP_W'(1);
      end else if (wr_now && gap_q != GAP_MAX) begin
        gap_q <= gap_q + GAP_W'(1);
      end
    end
  end

  // status byte index follows the frame index
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cs_frame_q <= '0;
      cs_byte_q <= '0;
    end else if (clock_en) begin
      cs_frame_q <= cs_frame_d;
      cs_byte_q <= CS_BYTE_W'(cs_frame_d >> CS_BYTE_SHIFT); // RL17
    end
  end

  // checks on the design's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  free_run_a: assert property ( // RL3
    clock_en && state_q == CTC_ARMED && !start && beat && cfg.sqw_mode
    && cfg.src <= SRC_TX_B |=> triggered_q && state_q != CTC_ARMED)
    else $error("free-run choice did not trigger at once");

  jit_gate_a: assert property ( // RL5
    clock_en && fire && cfg.src == SRC_JIT |-> ev.jit_gen_on)
    else $error("jitter trigger fired with generator off");

  one_trigger_a: assert property ( // RL23
    clock_en && triggered_q && !start |-> !fire)
    else $error("second trigger taken in one arming");

  pre_stop_a: assert property ( // RL4
    clock_en && fire && cfg.pre_mode |=> done_q ##1
    ($stable(wr_cnt_q) || $past(start)))
    else $error("pre-trigger capture did not stop at trigger");

  post_len_a: assert property ( // RL22
    clock_en && state_q == CTC_POST && wr_now && wr_cnt_q == LEN_LAST
    && !start |=> done_q && wr_cnt_q == LEN_FULL)
    else $error("post-trigger capture length wrong");

  err_mask_a: assert property ( // RL12
    clock_en && fire && cfg.src == SRC_RX_ERR
    |-> (ev.rx_err & cfg.err_mask) != '0)
    else $error("error trigger without an enabled error");

  ext_next_a: assert property ( // RL21
    clock_en && fire && cfg.src == SRC_EXT |-> ext_hit_q
    && $past(ext_edge || ext_hit_q))
    else $error("external trigger without a prior edge");

  cs_wrap_a: assert property ( // RL17
    clock_en && ev.rx_pre_a && !ev.rx_block && cs_frame_q == CS_LAST
    |=> cs_frame_q == '0 && cs_byte_q == '0)
    else $error("status block frame count wrong");

  edge_pol_a: assert property ( // RL2
    clock_en && wr_now && cfg.sqw_mode && cfg.sqw_rising && lvl_fall
    |-> !fifo_in[0])
    else $error("falling edge timed in rising mode");

endmodule : ctc_trigger
